// file: pkg/c7s_pkg.sv
// Constants for the channel 7 divider and PLL status register slice.
// Assumes a 16-bit register port with byte-wide register addresses.
package c7s_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_INT_DIV_FRAC_HIGH = 8'h13;
  localparam logic [7:0] ADDR_FRAC_DIV_LOW = 8'h14;
  localparam logic [7:0] ADDR_PLL_STATUS = 8'h15;
  // ==========================================================
  // Field positions
  localparam int INT_DIV_MSB = 11;
  localparam int INT_DIV_LSB = 4;
  localparam int FRAC_HIGH_MSB = 3;
  localparam int FRAC_HIGH_LSB = 0;
  localparam int STAT_UNLOCK_BIT = 2;
  localparam int STAT_REF_LOST_BIT = 1;
  localparam int STAT_REF_SEL_BIT = 0;
  localparam int STATUS_WIDTH = 3;
  // ==========================================================
  // Values after reset
  localparam logic [7:0] INT_DIV_RESET = 8'h00;
  localparam logic [3:0] FRAC_HIGH_RESET = 4'h0;
  localparam logic [15:0] FRAC_LOW_RESET = 16'h0000;
  localparam logic [15:0] READ_ZERO = 16'h0000;
  localparam logic RD_VALID_RESET = 1'h0;
  localparam logic [8:0] RATIO_RESET = 9'h001;
  localparam logic [19:0] FRAC_OUT_RESET = 20'h00000;
  localparam logic FRAC_ACT_RESET = 1'h0;
  // Pin shows unlocked until the status filter says otherwise
  localparam logic LOCK_PIN_RESET = 1'h0;
  // Live status starts as unlocked, reference lost, primary selected
  localparam logic [2:0] STATUS_RESET = 3'h6;
  localparam int SYNC_STAGES = 3;
endpackage

// file: verilog/c7s_status_sync.sv
// Three-stage synchroniser with agreement filter, one lane per bit.
// Assumes inputs are asynchronous to clk_sys; output changes only
// once the second and third stages agree.
module c7s_status_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // ==========================================================
  // Per-bit stages
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_lane
      logic s1_q, s2_q, s3_q, out_q;
      logic s1_d, s2_d, s3_d, out_d;
      always_comb begin
        s1_d = async_in[i];
        s2_d = s1_q;
        s3_d = s2_q;
        // First stage feeds only the second
        out_d = (s2_q == s3_q) ? s3_q : out_q;
      end
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          s1_q <= RESET_VAL[i];
          s2_q <= RESET_VAL[i];
          s3_q <= RESET_VAL[i];
          out_q <= RESET_VAL[i];
        end else begin
          s1_q <= s1_d;
          s2_q <= s2_d;
          s3_q <= s3_d;
          out_q <= out_d;
        end
      end
      assign sync_out[i] = out_q;
    end
  endgenerate
endmodule

// file: verilog/c7s_regs.sv
// Channel 7 divider registers and PLL status word.
// Assumes the serial port logic hands over single-cycle read and
// write strobes with address and data, on clk_sys.
module c7s_regs (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wr_data,
  output logic [15:0] reg_rd_data,
  output logic reg_rd_valid,
  input wire logic ch7_fractional_enable,
  input wire logic pll_unlock_async,
  input wire logic reference_lost_async,
  input wire logic ref_secondary_async,
  output logic [7:0] ch7_integer_divider,
  output logic [8:0] ch7_divide_ratio,
  output logic [19:0] ch7_fractional_divider,
  output logic ch7_fractional_active,
  output logic pll_lock_pin
);
  // ==========================================================
  // Status synchronisation
  logic [2:0] status_raw;
  logic [2:0] status_sync;
  assign status_raw[c7s_pkg::STAT_UNLOCK_BIT] = pll_unlock_async;
  assign status_raw[c7s_pkg::STAT_REF_LOST_BIT] = reference_lost_async;
  assign status_raw[c7s_pkg::STAT_REF_SEL_BIT] = ref_secondary_async;

  c7s_status_sync #(
    .WIDTH(c7s_pkg::STATUS_WIDTH),
    .RESET_VAL(c7s_pkg::STATUS_RESET)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(status_raw),
    .sync_out(status_sync)
  );

  // ==========================================================
  // Register decode
  // Writes to the status word or unmapped offsets match nothing here
  logic wr_int_hit;
  logic wr_low_hit;
  assign wr_int_hit = reg_wr_en && (reg_addr == c7s_pkg::ADDR_INT_DIV_FRAC_HIGH);
  assign wr_low_hit = reg_wr_en && (reg_addr == c7s_pkg::ADDR_FRAC_DIV_LOW);

  // ==========================================================
  // Integer divider field
  logic [7:0] int_div_q;
  logic [7:0] int_div_d;

  always_comb begin
    int_div_d = int_div_q;
    if (wr_int_hit) begin
      // Bits 15:12 are not stored, so a careless host cannot set them
      int_div_d = reg_wr_data[c7s_pkg::INT_DIV_MSB:c7s_pkg::INT_DIV_LSB];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_div_q <= c7s_pkg::INT_DIV_RESET;
    end else begin
      int_div_q <= int_div_d;
    end
  end

  // ==========================================================
  // Fraction upper bits
  logic [3:0] frac_high_q;
  logic [3:0] frac_high_d;

  always_comb begin
    frac_high_d = frac_high_q;
    if (wr_int_hit) begin
      frac_high_d = reg_wr_data[c7s_pkg::FRAC_HIGH_MSB:c7s_pkg::FRAC_HIGH_LSB];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frac_high_q <= c7s_pkg::FRAC_HIGH_RESET;
    end else begin
      frac_high_q <= frac_high_d;
    end
  end

  // ==========================================================
  // Fraction lower bits
  // No atomic update: the halves land on separate writes
  logic [15:0] frac_low_q;
  logic [15:0] frac_low_d;

  always_comb begin
    frac_low_d = frac_low_q;
    if (wr_low_hit) begin
      frac_low_d = reg_wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frac_low_q <= c7s_pkg::FRAC_LOW_RESET;
    end else begin
      frac_low_q <= frac_low_d;
    end
  end

  // ==========================================================
  // Read data
  logic [15:0] rd_data_q;
  logic [15:0] rd_data_d;

  always_comb begin
    rd_data_d = rd_data_q;
    if (reg_rd_en) begin
      case (reg_addr)
        c7s_pkg::ADDR_INT_DIV_FRAC_HIGH: rd_data_d = {4'h0, int_div_q, frac_high_q};
        c7s_pkg::ADDR_FRAC_DIV_LOW: rd_data_d = frac_low_q;
        // Unused status bits tied low; writes here are ignored
        c7s_pkg::ADDR_PLL_STATUS: rd_data_d = {13'h0000, status_sync};
        default: rd_data_d = c7s_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data_q <= c7s_pkg::READ_ZERO;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  // ==========================================================
  // Read valid
  logic rd_valid_q;
  logic rd_valid_d;

  always_comb begin
    rd_valid_d = reg_rd_en;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_valid_q <= c7s_pkg::RD_VALID_RESET;
    end else begin
      rd_valid_q <= rd_valid_d;
    end
  end

  // ==========================================================
  // Divide ratio
  // Nine bits so that a field of all ones still divides by 256
  logic [8:0] ratio_q;
  logic [8:0] ratio_d;

  always_comb begin
    ratio_d = {1'h0, int_div_q} + 9'h001;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ratio_q <= c7s_pkg::RATIO_RESET;
    end else begin
      ratio_q <= ratio_d;
    end
  end

  // ==========================================================
  // Fraction output
  logic [19:0] frac_out_q;
  logic [19:0] frac_out_d;

  always_comb begin
    // Zeroed fraction when disabled keeps the datapath integer-only
    frac_out_d = c7s_pkg::FRAC_OUT_RESET;
    if (ch7_fractional_enable) begin
      frac_out_d = {frac_high_q, frac_low_q};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frac_out_q <= c7s_pkg::FRAC_OUT_RESET;
    end else begin
      frac_out_q <= frac_out_d;
    end
  end

  // ==========================================================
  // Fraction active flag
  logic frac_act_q;
  logic frac_act_d;

  always_comb begin
    frac_act_d = ch7_fractional_enable;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frac_act_q <= c7s_pkg::FRAC_ACT_RESET;
    end else begin
      frac_act_q <= frac_act_d;
    end
  end

  // ==========================================================
  // Lock pin
  // Taken from the filtered status so pin and register never disagree
  logic lock_pin_q;
  logic lock_pin_d;

  always_comb begin
    lock_pin_d = ~status_sync[c7s_pkg::STAT_UNLOCK_BIT];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lock_pin_q <= c7s_pkg::LOCK_PIN_RESET;
    end else begin
      lock_pin_q <= lock_pin_d;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rd_data = rd_data_q;
  assign reg_rd_valid = rd_valid_q;
  assign ch7_integer_divider = int_div_q;
  assign ch7_divide_ratio = ratio_q;
  assign ch7_fractional_divider = frac_out_q;
  assign ch7_fractional_active = frac_act_q;
  assign pll_lock_pin = lock_pin_q;
endmodule

// file: tb/c7s_regs_monitor.sv
// Checker for the channel 7 register slice.
// Assumes the bind below attaches it to c7s_regs.
module c7s_regs_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wr_data,
  input wire logic [15:0] reg_rd_data,
  input wire logic reg_rd_valid,
  input wire logic ch7_fractional_enable,
  input wire logic pll_unlock_async,
  input wire logic [7:0] ch7_integer_divider,
  input wire logic [8:0] ch7_divide_ratio,
  input wire logic [19:0] ch7_fractional_divider,
  input wire logic pll_lock_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==============
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence low_wr_s;
    reg_wr_en && reg_addr == 8'h14 ##1 ch7_fractional_enable;
  endsequence
  rd_valid_a: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("no read valid");
  int_wr_a: assert property (reg_wr_en && reg_addr == 8'h13 |=> ch7_integer_divider == $past(reg_wr_data[11:4]))
    else $error("divider not stored");
  div_ratio_a: assert property (ch7_divide_ratio == {1'h0, $past(ch7_integer_divider)} + 9'h001)
    else $error("ratio wrong");
  top_zero_a: assert property (reg_rd_en && reg_addr == 8'h13 |=> reg_rd_data[15:12] == 4'h0)
    else $error("top bits set");
  stat_zero_a: assert property (reg_rd_en && reg_addr == 8'h15 |=> reg_rd_data[15:3] == 13'h0000)
    else $error("status upper bits set");
  frac_off_a: assert property (!ch7_fractional_enable |=> ch7_fractional_divider == 20'h00000)
    else $error("fraction not gated");
  frac_low_a: assert property (low_wr_s |=> ch7_fractional_divider[15:0] == $past(reg_wr_data, 2))
    else $error("fraction low wrong");
  // Seven samples cover the filter delay plus the pin register
  lock_pin_a: assert property (pll_unlock_async [*7] |-> !pll_lock_pin)
    else $error("lock pin wrong");
endmodule
bind c7s_regs c7s_regs_monitor mon_u (
  .clk_sys(clk_sys),
  .rst(rst),
  .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr),
  .reg_wr_data(reg_wr_data),
  .reg_rd_data(reg_rd_data),
  .reg_rd_valid(reg_rd_valid),
  .ch7_fractional_enable(ch7_fractional_enable),
  .pll_unlock_async(pll_unlock_async),
  .ch7_integer_divider(ch7_integer_divider),
  .ch7_divide_ratio(ch7_divide_ratio),
  .ch7_fractional_divider(ch7_fractional_divider),
  .pll_lock_pin(pll_lock_pin)
);

// file: tb/c7s_host_model.sv
// Host model for the register port.
// Assumes strobes are sampled on rising clk_sys.
module c7s_host_model (
  input wire logic clk_sys,
  input wire logic [15:0] reg_rd_data,
  input wire logic reg_rd_valid,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==============
  // Transfers
  initial begin
    reg_wr_en = 1'h0;
    reg_rd_en = 1'h0;
    reg_addr = 8'h00;
    reg_wr_data = 16'h0000;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wr_data = (a == 8'h13) ? {4'h0, d[11:0]} : d;
    reg_wr_en = 1'h1;
    @(negedge clk_sys);
    reg_wr_en = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd_en = 1'h1;
    @(negedge clk_sys);
    reg_rd_en = 1'h0;
    q = reg_rd_valid ? reg_rd_data : 16'hxxxx;
  endtask
endmodule

// file: tb/c7s_regs_tb_top.sv
// Bench for the channel 7 register slice.
// Assumes the host model drives the port on falling edges.
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module c7s_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic ch7_fractional_enable = 1'h0;
  logic pll_unlock_async = 1'h0;
  logic reference_lost_async = 1'h0;
  logic ref_secondary_async = 1'h0;
  logic reg_wr_en, reg_rd_en, reg_rd_valid, ch7_fractional_active, pll_lock_pin;
  logic [7:0] reg_addr, ch7_integer_divider;
  logic [15:0] reg_wr_data, reg_rd_data, q;
  logic [8:0] ch7_divide_ratio;
  logic [19:0] ch7_fractional_divider;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  c7s_host_model host_u (
    .clk_sys(clk_sys),
    .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid),
    .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data)
  );
  c7s_regs dut_u (
    .clk_sys(clk_sys),
    .rst(rst),
    .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid),
    .ch7_fractional_enable(ch7_fractional_enable),
    .pll_unlock_async(pll_unlock_async),
    .reference_lost_async(reference_lost_async),
    .ref_secondary_async(ref_secondary_async),
    .ch7_integer_divider(ch7_integer_divider),
    .ch7_divide_ratio(ch7_divide_ratio),
    .ch7_fractional_divider(ch7_fractional_divider),
    .ch7_fractional_active(ch7_fractional_active),
    .pll_lock_pin(pll_lock_pin)
  );
  initial forever #4 clk_sys = ~clk_sys;
  // ==============
  // Sequence
  task automatic close_out();
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    repeat (8) @(negedge clk_sys);
    rst = 1'h0;
    host_u.wr(8'h13, 16'hfab5);
    host_u.rd(8'h13, q);
    `CHK("int reg", 16'h0ab5, q)
    `CHK("int div", 8'hab, ch7_integer_divider)
    `CHK("ratio", 9'h0ac, ch7_divide_ratio)
    host_u.wr(8'h14, 16'h1234);
    ch7_fractional_enable = 1'h1;
    host_u.rd(8'h14, q);
    `CHK("low reg", 16'h1234, q)
    `CHK("fraction", 20'h51234, ch7_fractional_divider)
    `CHK("active", 1'h1, ch7_fractional_active)
    ch7_fractional_enable = 1'h0;
    host_u.wr(8'h15, 16'hffff);
    `CHK("gated", 20'h00000, ch7_fractional_divider)
    // Every status code, with settling time for the synchroniser
    for (int i = 0; i < 8; i++) begin
      {pll_unlock_async, reference_lost_async, ref_secondary_async} = i[2:0];
      repeat (6) @(negedge clk_sys);
      host_u.rd(8'h15, q);
      `CHK("status", ({13'h0000, i[2:0]}), q)
      `CHK("lock pin", ~i[2], pll_lock_pin)
    end
    host_u.rd(8'h16, q);
    `CHK("unmapped", 16'h0000, q)
    close_out();
  end
endmodule
